/* core/epi_defines.svh */
// Register offsets, field positions, reset values and encodings of the pin interrupt block.
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
`define EPI_OFS_EDGE_SELECT 12'h000
`define EPI_OFS_PRIMARY_CTRL 12'h004
`define EPI_OFS_LARGE_CTRL 12'h008
`define EPI_OFS_EVENT_STATUS 12'h00C
`define EPI_OFS_EVENT_MASK 12'h010
`define EPI_RST_EDGE_SELECT 8'h00
`define EPI_RST_PRIMARY_CTRL 8'h00
`define EPI_RST_LARGE_CTRL 8'h00
`define EPI_RST_EVENT_MASK 4'h0
`define EPI_PIN_COUNT 4
`define EPI_EDGE_DISABLED 2'h0
`define EPI_EDGE_RISING 2'h1
`define EPI_EDGE_FALLING 2'h2
`define EPI_EDGE_BOTH 2'h3
`define EPI_BIT_GLOBAL_EN 0
`define EPI_BIT_PIN0_EN 1
`define EPI_BIT_PIN1_EN 2
`define EPI_BIT_PIN2_EN 3
`define EPI_BIT_PIN0_FLAG 4
`define EPI_BIT_PIN1_FLAG 5
`define EPI_BIT_PIN2_FLAG 6
`define EPI_BIT_PIN3_EN 0
`define EPI_BIT_PIN3_FLAG 4
`define EPI_CTRL_WRITABLE 8'h7F
`define EPI_LARGE_WRITABLE 8'h11
`endif

/* core/epi_pkg.sv */
// Types shared by the pin interrupt block.
package epi_pkg;
    typedef logic [1:0] epi_edge_t;
    typedef logic [7:0] epi_byte_t;
    typedef enum logic [2:0] {
        EPI_IDLE = 3'b001,
        EPI_SETUP = 3'b010,
        EPI_ACCESS = 3'b100
    } epi_apb_e;
endpackage

/* core/epi_edge_if.sv */
// Interface carrying pin levels, edge selects and detected events between modules.
`timescale 1ns/1ps
interface epi_edge_if;
    logic [3:0] pinLevel;
    logic [7:0] edgeSelect;
    logic [3:0] edgeHit;
    modport detector (input pinLevel, input edgeSelect, output edgeHit);
    modport owner (output pinLevel, output edgeSelect, input edgeHit);
endinterface

/* core/epi_edge_detect.sv */
// Per-pin synchroniser and edge detector steered by the two-bit select fields.
`timescale 1ns/1ps
`include "epi_defines.svh"
module epi_edge_detect (
    input wire logic clock,
    input wire logic resetn,
    epi_edge_if.detector edges
);
    import epi_pkg::*;
    logic [3:0] syncFirst_ff;
    logic [3:0] syncSecond_ff;
    logic [3:0] prevLevel_ff;
    logic [2:0] primeShift_ff;
    logic primed;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            syncFirst_ff <= 4'h0;
            syncSecond_ff <= 4'h0;
            prevLevel_ff <= 4'h0;
        end else begin
            syncFirst_ff <= edges.pinLevel;
            syncSecond_ff <= syncFirst_ff;
            prevLevel_ff <= syncSecond_ff;
        end
    end
    // Both synchroniser stages and the history need three edges to hold real pin samples.
    // Until then a pin that is high at reset would look like a rising edge, so it is ignored.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            primeShift_ff <= 3'h0;
        end else begin
            primeShift_ff <= {primeShift_ff[1:0], 1'b1};
        end
    end
    assign primed = primeShift_ff[2];
    genvar gi;
    generate
        for (gi = 0; gi < `EPI_PIN_COUNT; gi++) begin : gPin
            epi_edge_t sel;
            logic rise;
            logic fall;
            assign sel = edges.edgeSelect[2*gi+1:2*gi];
            assign rise = primed & syncSecond_ff[gi] & ~prevLevel_ff[gi];
            assign fall = primed & ~syncSecond_ff[gi] & prevLevel_ff[gi];
            // Select 00 yields no event.
            assign edges.edgeHit[gi] =
                ((sel == `EPI_EDGE_RISING) & rise) |
                ((sel == `EPI_EDGE_FALLING) & fall) |
                ((sel == `EPI_EDGE_BOTH) & (rise | fall));
        end
    endgenerate
endmodule

/* core/epi_apb_slave.sv */
// APB slave front end: decodes transfers into one-cycle read and write strobes.
`timescale 1ns/1ps
module epi_apb_slave (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    output logic pready,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic [11:0] regAddr
);
    import epi_pkg::*;
    epi_apb_e state_ff;
    epi_apb_e nxt_state;
    // Zero wait states. The state reads SETUP in the cycle after a setup edge, which is the access
    // phase, so pready answers there and never while the bus is idle or between transfers.
    assign pready = (state_ff == EPI_SETUP) & psel & penable;
    assign wrStrobe = psel & penable & pwrite & pready;
    assign rdStrobe = psel & penable & ~pwrite & pready;
    assign regAddr = paddr;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            EPI_IDLE: begin
                if (psel) begin
                    nxt_state = EPI_SETUP;
                end
            end
            EPI_SETUP: begin
                nxt_state = EPI_ACCESS;
            end
            EPI_ACCESS: begin
                nxt_state = psel ? EPI_SETUP : EPI_IDLE;
            end
            default: begin
                nxt_state = EPI_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= EPI_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

/* core/epi_pin_irq.sv */
// Top of the external pin interrupt block: registers, request flags and interrupt output.
`timescale 1ns/1ps
`include "epi_defines.svh"
module epi_pin_irq (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extIrqPinA,
    input wire logic extIrqPinB,
    input wire logic extIrqPinC,
    input wire logic extIrqPinD,
    output logic cpuIrqRequest,
    output logic eventIrq
);
    import epi_pkg::*;

    // ********************************
    // Edge detection and bus front end
    // ********************************
    epi_edge_if edges ();
    logic wrStrobe;
    logic rdStrobe;
    logic [11:0] regAddr;
    epi_byte_t edgeSelect_ff;
    epi_byte_t primaryCtrl_ff;
    epi_byte_t largeCtrl_ff;
    logic [3:0] eventStatus_ff;
    logic [3:0] eventMask_ff;

    assign edges.pinLevel = {extIrqPinD, extIrqPinC, extIrqPinB, extIrqPinA};
    assign edges.edgeSelect = edgeSelect_ff;

    epi_edge_detect u_detect (
        .clock(clock),
        .resetn(resetn),
        .edges(edges.detector)
    );

    epi_apb_slave u_apb (
        .clock(clock),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .regAddr(regAddr)
    );

    logic hitEdge;
    logic hitPrimary;
    logic hitLarge;
    logic hitStatus;
    logic hitMask;
    logic hitAny;
    assign hitEdge = (regAddr == `EPI_OFS_EDGE_SELECT);
    assign hitPrimary = (regAddr == `EPI_OFS_PRIMARY_CTRL);
    assign hitLarge = (regAddr == `EPI_OFS_LARGE_CTRL);
    assign hitStatus = (regAddr == `EPI_OFS_EVENT_STATUS);
    assign hitMask = (regAddr == `EPI_OFS_EVENT_MASK);
    assign hitAny = hitEdge | hitPrimary | hitLarge | hitStatus | hitMask;
    // Unmapped addresses answer with an error; writes there change nothing.
    assign pslverr = pready & psel & penable & ~hitAny;

    // ********************************
    // Edge select register
    // ********************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            edgeSelect_ff <= `EPI_RST_EDGE_SELECT;
        end else if (wrStrobe && hitEdge) begin
            // Pin 3 keeps 11 as written; it reads as both edges like the others.
            edgeSelect_ff <= pwdata[7:0];
        end
    end

    // ********************************
    // Request flags and enables
    // ********************************
    logic [3:0] hit;
    assign hit = edges.edgeHit;

    // Flags are software writable; a new edge wins over a write of zero in the same cycle.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            primaryCtrl_ff <= `EPI_RST_PRIMARY_CTRL;
        end else begin
            if (wrStrobe && hitPrimary) begin
                primaryCtrl_ff <= pwdata[7:0] & `EPI_CTRL_WRITABLE;
            end
            if (hit[0]) begin
                primaryCtrl_ff[`EPI_BIT_PIN0_FLAG] <= 1'b1;
            end
            if (hit[1]) begin
                primaryCtrl_ff[`EPI_BIT_PIN1_FLAG] <= 1'b1;
            end
            if (hit[2]) begin
                primaryCtrl_ff[`EPI_BIT_PIN2_FLAG] <= 1'b1;
            end
        end
    end

    // Pin 3 enable and flag live in a register of their own.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            largeCtrl_ff <= `EPI_RST_LARGE_CTRL;
        end else begin
            if (wrStrobe && hitLarge) begin
                largeCtrl_ff <= pwdata[7:0] & `EPI_LARGE_WRITABLE;
            end
            if (hit[3]) begin
                largeCtrl_ff[`EPI_BIT_PIN3_FLAG] <= 1'b1;
            end
        end
    end

    // ********************************
    // CPU request
    // ********************************
    logic [3:0] pinFlag;
    logic [3:0] pinEnable;
    assign pinFlag = {largeCtrl_ff[`EPI_BIT_PIN3_FLAG], primaryCtrl_ff[`EPI_BIT_PIN2_FLAG],
                      primaryCtrl_ff[`EPI_BIT_PIN1_FLAG], primaryCtrl_ff[`EPI_BIT_PIN0_FLAG]};
    assign pinEnable = {largeCtrl_ff[`EPI_BIT_PIN3_EN], primaryCtrl_ff[`EPI_BIT_PIN2_EN],
                        primaryCtrl_ff[`EPI_BIT_PIN1_EN], primaryCtrl_ff[`EPI_BIT_PIN0_EN]};
    // The request is a plain level; the CPU acknowledges by clearing the flag.
    assign cpuIrqRequest = primaryCtrl_ff[`EPI_BIT_GLOBAL_EN] & |(pinFlag & pinEnable);

    // ********************************
    // Event status and mask
    // ********************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            eventStatus_ff <= 4'h0;
        end else begin
            // Set beats write-one-to-clear when both land together.
            if (wrStrobe && hitStatus) begin
                eventStatus_ff <= (eventStatus_ff & ~pwdata[3:0]) | hit;
            end else begin
                eventStatus_ff <= eventStatus_ff | hit;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            eventMask_ff <= `EPI_RST_EVENT_MASK;
        end else if (wrStrobe && hitMask) begin
            eventMask_ff <= pwdata[3:0];
        end
    end

    assign eventIrq = |(eventStatus_ff & eventMask_ff);

    // ********************************
    // Read data
    // ********************************
    logic [31:0] nxt_prdata;
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hitEdge) begin
            nxt_prdata = {24'h00_0000, edgeSelect_ff};
        end else if (hitPrimary) begin
            nxt_prdata = {24'h00_0000, primaryCtrl_ff};
        end else if (hitLarge) begin
            nxt_prdata = {24'h00_0000, largeCtrl_ff};
        end else if (hitStatus) begin
            nxt_prdata = {28'h000_0000, eventStatus_ff};
        end else if (hitMask) begin
            nxt_prdata = {28'h000_0000, eventMask_ff};
        end
    end

    // Data is registered in the setup cycle so it stands for the whole access phase.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= nxt_prdata;
        end
    end
endmodule

/* verif/epi_pin_model.sv */
// Behavioural model of the four external interrupt pins.
`timescale 1ns/1ps
module epi_pin_model (
    input wire logic clock,
    input wire logic [3:0] want,
    input wire logic slow,
    output logic [3:0] pins
);
    logic [3:0] stage_ff;
    // A slow pin lags its request by one clock, like a weak external driver.
    always_ff @(posedge clock) begin
        stage_ff <= want;
    end
    assign pins = slow ? stage_ff : want;
endmodule

/* verif/epi_pin_irq_assertions.sv */
// Port checker for the pin interrupt block.
`timescale 1ns/1ps
module epi_pin_irq_assertions (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic extIrqPinA,
    input wire logic extIrqPinB,
    input wire logic extIrqPinC,
    input wire logic extIrqPinD,
    input wire logic cpuIrqRequest,
    input wire logic eventIrq
);
    logic wr;
    logic [7:0] ctl_ff;
    logic [7:0] sel_ff;
    logic big_ff;
    logic [3:0] msk_ff;
    // Shadows of software writes; hardware never changes the enable, select and mask fields checked here, only the flag bits.
    assign wr = psel && penable && pready && pwrite;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctl_ff <= 8'h00;
            sel_ff <= 8'h00;
            big_ff <= 1'b0;
            msk_ff <= 4'h0;
        end else if (wr) begin
            if (paddr == 12'h004) ctl_ff <= pwdata[7:0];
            if (paddr == 12'h000) sel_ff <= pwdata[7:0];
            if (paddr == 12'h008) big_ff <= pwdata[0];
            if (paddr == 12'h010) msk_ff <= pwdata[3:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_ready_access: assert property (psel && penable |-> pready) else $error("no ready");
    a_idle_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
        else $error("idle answer");
    a_err_map: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 12'h010)) else $error("bad slverr");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved");
    a_irq_gated: assert property (
        cpuIrqRequest |-> ctl_ff[0] && (ctl_ff[3:1] != 3'h0 || big_ff)) else $error("irq ungated");
    a_global_off: assert property (
        wr && paddr == 12'h004 && !pwdata[0] |=> !cpuIrqRequest) else $error("global off");
    a_pin0_rise: assert property (
        sel_ff[1:0] == 2'h1 && ctl_ff[1:0] == 2'h3 && $rose(extIrqPinA) |-> ##[1:5] cpuIrqRequest)
        else $error("pin0 edge lost");
    a_pin3_rise: assert property (
        sel_ff[7:6] == 2'h1 && ctl_ff[0] && big_ff && $rose(extIrqPinD) |-> ##[1:5] cpuIrqRequest)
        else $error("pin3 edge lost");
    a_event_masked: assert property (eventIrq |-> msk_ff != 4'h0) else $error("event unmasked");
    cover property ($rose(cpuIrqRequest));
    cover property ($rose(eventIrq));
    cover property (pslverr);
endmodule
bind epi_pin_irq epi_pin_irq_assertions chk (.*);

/* verif/ext_pin_irq_edge_and_enable_tb.sv */
// Self-checking bench for the pin interrupt block.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ext_pin_irq_edge_and_enable_tb;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, cpuIrqRequest, eventIrq;
    logic err, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] want, pins;
    int error_cnt, check_count, cyc;
    epi_pin_irq uut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extIrqPinA(pins[0]), .extIrqPinB(pins[1]), .extIrqPinC(pins[2]),
        .extIrqPinD(pins[3]), .cpuIrqRequest(cpuIrqRequest), .eventIrq(eventIrq));
    epi_pin_model pinModel (.clock(clock), .want(want), .slow(slow), .pins(pins));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic hitExp(input logic [1:0] s, input logic lvl);
        return (s == 2'h1 && lvl) || (s == 2'h2 && !lvl) || s == 2'h3;
    endfunction
    function automatic logic irqExp(input logic [7:0] c, input logic [7:0] g);
        return c[0] && ((c[4] && c[1]) || (c[5] && c[2]) || (c[6] && c[3]) || (g[4] && g[0]));
    endfunction
    task automatic stop_test();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic trial(input int p, input logic [1:0] s);
        logic h;
        logic [3:0] m;
        apb(1'b1, 12'h00C, 32'h0F);
        apb(1'b1, 12'h004, 32'h0F);
        apb(1'b1, 12'h008, 32'h01);
        apb(1'b1, 12'h000, 32'(s) << (2 * p));
        h = hitExp(s, !want[p]);
        want[p] <= !want[p];
        repeat (6) @(posedge clock);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rd[3:0], 4'(h) << p)
        apb(1'b0, (p == 3) ? 12'h008 : 12'h004, 32'h0);
        `CHK(rd[7:0], (p == 3) ? {3'h0, h, 4'h1} : 8'h0F | (8'(h) << (4 + p)))
        seed = xs(seed);
        m = seed[3:0];
        apb(1'b1, 12'h010, 32'(m));
        @(negedge clock);
        `CHK(eventIrq, |(m & (4'(h) << p)))
        `CHK(cpuIrqRequest, h)
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        logic [7:0] msk [5];
        msk = '{8'hFF, 8'h7F, 8'h11, 8'h00, 8'h0F};
        {resetn, psel, penable, pwrite, paddr, pwdata, want, slow} = '0;
        seed = 32'h62EA;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            `CHK({err, rd}, {i == 5, 32'h0})
            apb(1'b1, 12'(4 * i), 32'hFF);
            apb(1'b0, 12'(4 * i), 32'h0);
            `CHK({err, rd}, {i == 5, (i < 5) ? 24'h0 : 24'h0, (i < 5) ? msk[i] : 8'h00})
        end
        $display("registers done");
        for (int i = 0; i < 32; i++)
            trial(i / 8, 2'(i / 2));
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            slow <= seed[4];
            trial(seed[1:0], seed[3:2]);
        end
        $display("edges done");
        for (int i = 0; i < 128; i++) begin
            seed = xs(seed);
            apb(1'b1, 12'h004, {25'h0, seed[6:0]});
            apb(1'b1, 12'h008, {24'h0, seed[15:8]});
            @(negedge clock);
            `CHK(cpuIrqRequest, irqExp({1'b0, seed[6:0]}, seed[15:8] & 8'h11))
        end
        $display("enables done");
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        `CHK({cpuIrqRequest, eventIrq}, 2'h0)
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            `CHK(rd, 32'h0)
        end
        $display("reset done");
        stop_test();
    end
endmodule
